// File: mdiob_defines.svh
`ifndef MDIOB_DEFINES_SVH
`define MDIOB_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------
`define MDIOB_CLK_PERIOD_NS 8
`define MDIOB_CAP_FILT_MIN_NS 50
`define MDIOB_CAP_FILT_MAX_NS 12900
`define MDIOB_CAP_FILT_MIN_CYC ((`MDIOB_CAP_FILT_MIN_NS + `MDIOB_CLK_PERIOD_NS - 1) / `MDIOB_CLK_PERIOD_NS)
`define MDIOB_CAP_FILT_MAX_CYC (`MDIOB_CAP_FILT_MAX_NS / `MDIOB_CLK_PERIOD_NS)
`define MDIOB_TRIP_RESP_NS 150
`define MDIOB_TRIP_RESP_CYC (`MDIOB_TRIP_RESP_NS / `MDIOB_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Widths and group selection codes.
// ----------------------------------------------------------------
`define MDIOB_NPTS 8
`define MDIOB_CNT_W 11
`define MDIOB_POS_W 32
`define MDIOB_ADC_W 10
`define MDIOB_GRP_LOWER 2'h0
`define MDIOB_GRP_UPPER 2'h1
`define MDIOB_GRP_ALL 2'h2

`endif

// File: mdiob_pkg.sv
package mdiob_pkg;
  // Function assigned to a general purpose output point.
  typedef enum logic [2:0] {
    MDIOB_FN_USER,
    MDIOB_FN_MOVING,
    MDIOB_FN_FAULT,
    MDIOB_FN_STALL,
    MDIOB_FN_VELCHG
  } mdiob_func_t;
endpackage

// File: mdiob_filt_if.sv
`include "mdiob_defines.svh"

interface mdiob_filt_if;
  logic raw;
  logic [`MDIOB_CNT_W-1:0] limit;
  logic level;
  logic rise;
  modport host (output raw, output limit, input level, input rise);
  modport filt (input raw, input limit, output level, output rise);
endinterface

// File: mdiob_filt.sv
`include "mdiob_defines.svh"

module mdiob_filt (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Filter signals.
  mdiob_filt_if.filt fi
);
  logic level_ff;
  logic rise_ff;
  logic [`MDIOB_CNT_W-1:0] cnt_ff;
  logic differ;
  logic settle;
  logic [`MDIOB_CNT_W-1:0] nxt_cnt;

  // A new level must persist for the programmed number of cycles.
  assign differ = fi.raw != level_ff;
  assign settle = differ && (cnt_ff >= fi.limit - `MDIOB_CNT_W'(1));
  assign nxt_cnt = (differ && !settle) ? cnt_ff + `MDIOB_CNT_W'(1) : '0;
  assign fi.level = level_ff;
  assign fi.rise = rise_ff;

  // Count the run of the differing level and flip once it settles.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      rise_ff <= settle && fi.raw;
      if (settle) level_ff <= fi.raw;
    end
  end
endmodule // mdiob_filt

// File: mdiob_top.sv
`include "mdiob_defines.svh"

module mdiob_top import mdiob_pkg::*; (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // General purpose point pins, bit 0..3 = points one..four, 4..7 = nine..twelve.
  input wire logic [`MDIOB_NPTS-1:0] PT_IN,
  output logic [`MDIOB_NPTS-1:0] PT_OUT,
  output logic [`MDIOB_NPTS-1:0] PT_OE_B,
  // Point configuration.
  input wire logic [`MDIOB_NPTS-1:0] CFG_IS_OUT,
  input wire logic [`MDIOB_NPTS-1:0] CFG_ACT_HIGH,
  input wire logic [3*`MDIOB_NPTS-1:0] CFG_FUNC,
  // Motion state.
  input wire logic MOT_MOVING,
  input wire logic MOT_FAULT,
  input wire logic MOT_STALL,
  input wire logic ENC_PRESENT,
  input wire logic MOT_VEL_CHG,
  // Group access from the program.
  input wire logic [1:0] GRP_SEL,
  input wire logic GRP_WR,
  input wire logic [`MDIOB_NPTS-1:0] GRP_WDATA,
  input wire logic GRP_RD,
  output logic [`MDIOB_NPTS-1:0] GRP_RDATA,
  output logic [11:0] GRP_RDEC,
  output logic GRP_RVALID,
  // Dedicated capture / trip point.
  input wire logic DED_IN,
  output logic DED_OUT,
  output logic DED_OE_B,
  input wire logic DED_IS_TRIP,
  input wire logic DED_ACT_HIGH,
  input wire logic [`MDIOB_CNT_W-1:0] CAP_FILT_CYC,
  input wire logic [`MDIOB_POS_W-1:0] POS_COUNT,
  output logic [`MDIOB_POS_W-1:0] CAP_VALUE,
  output logic CAP_STB,
  input wire logic [`MDIOB_POS_W-1:0] TRIP_VALUE,
  input wire logic TRIP_REARM,
  output logic TRIP_FIRED,
  // Analog input results.
  input wire logic ADC_VALID,
  input wire logic [`MDIOB_ADC_W-1:0] ADC_DATA,
  input wire logic [`MDIOB_ADC_W-1:0] ANA_THRESH,
  output logic [`MDIOB_ADC_W-1:0] ANA_VALUE,
  output logic ANA_ABOVE
);
  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  // Binary to three decimal digits by shift and add-three.
  function automatic logic [11:0] to_dec(input logic [7:0] bin);
    logic [19:0] s;
    s = {12'h000, bin};
    for (int i = 0; i < 8; i++) begin
      if (s[11:8] > 4'h4) s[11:8] = s[11:8] + 4'h3;
      if (s[15:12] > 4'h4) s[15:12] = s[15:12] + 4'h3;
      if (s[19:16] > 4'h4) s[19:16] = s[19:16] + 4'h3;
      s = s << 1;
    end
    return s[19:8];
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [`MDIOB_NPTS-1:0] pt_s1_ff, pt_s2_ff;
  logic ded_s1_ff, ded_s2_ff;

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pt_s1_ff <= '0;
      pt_s2_ff <= '0;
      ded_s1_ff <= 1'b0;
      ded_s2_ff <= 1'b0;
    end else begin
      pt_s1_ff <= PT_IN;
      pt_s2_ff <= pt_s1_ff;
      ded_s1_ff <= DED_IN;
      ded_s2_ff <= ded_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // General purpose points.
  // ----------------------------------------------------------------
  logic [`MDIOB_NPTS-1:0] user_ff;
  logic [`MDIOB_NPTS-1:0] nxt_user;
  logic [`MDIOB_NPTS-1:0] in_state;
  logic [`MDIOB_NPTS-1:0] out_state;
  logic [`MDIOB_NPTS-1:0] grp_val;
  logic stall_act;

  // Logical state is the pin level, inverted for active low points.
  assign in_state = pt_s2_ff ^ ~CFG_ACT_HIGH;
  assign stall_act = MOT_STALL && ENC_PRESENT;

  // Each output point picks its source from its configured function.
  always_comb begin
    for (int i = 0; i < `MDIOB_NPTS; i++) begin
      case (mdiob_func_t'(CFG_FUNC[3*i +: 3]))
        MDIOB_FN_USER: out_state[i] = user_ff[i];
        MDIOB_FN_MOVING: out_state[i] = MOT_MOVING;
        MDIOB_FN_FAULT: out_state[i] = MOT_FAULT;
        MDIOB_FN_STALL: out_state[i] = stall_act;
        MDIOB_FN_VELCHG: out_state[i] = MOT_VEL_CHG;
        default: out_state[i] = 1'b0;
      endcase
    end
  end

  // Group writes place the written number on the chosen points.
  always_comb begin
    nxt_user = user_ff;
    if (GRP_WR) begin
      case (GRP_SEL)
        `MDIOB_GRP_LOWER: nxt_user[3:0] = GRP_WDATA[3:0];
        `MDIOB_GRP_UPPER: nxt_user[7:4] = GRP_WDATA[3:0];
        `MDIOB_GRP_ALL: nxt_user = GRP_WDATA;
        default: nxt_user = user_ff;
      endcase
    end
  end

  // Group reads gather the logical input states as one number.
  always_comb begin
    case (GRP_SEL)
      `MDIOB_GRP_LOWER: grp_val = {4'h0, in_state[3:0]};
      `MDIOB_GRP_UPPER: grp_val = {4'h0, in_state[7:4]};
      `MDIOB_GRP_ALL: grp_val = in_state;
      default: grp_val = 8'h00;
    endcase
  end

  // Registered pin drive, user levels and read answers.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      user_ff <= '0;
      PT_OUT <= '0;
      PT_OE_B <= '1;
      GRP_RDATA <= '0;
      GRP_RDEC <= 12'h000;
      GRP_RVALID <= 1'b0;
    end else begin
      user_ff <= nxt_user;
      PT_OUT <= out_state ^ ~CFG_ACT_HIGH;
      PT_OE_B <= ~CFG_IS_OUT;
      GRP_RVALID <= GRP_RD;
      if (GRP_RD) begin
        GRP_RDATA <= grp_val;
        GRP_RDEC <= to_dec(grp_val);
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture input.
  // ----------------------------------------------------------------
  mdiob_filt_if cap_if ();
  logic [`MDIOB_CNT_W-1:0] filt_lim;

  // Keep the filter setting inside its documented span.
  assign filt_lim = (CAP_FILT_CYC < `MDIOB_CNT_W'(`MDIOB_CAP_FILT_MIN_CYC)) ?
                    `MDIOB_CNT_W'(`MDIOB_CAP_FILT_MIN_CYC) :
                    (CAP_FILT_CYC > `MDIOB_CNT_W'(`MDIOB_CAP_FILT_MAX_CYC)) ?
                    `MDIOB_CNT_W'(`MDIOB_CAP_FILT_MAX_CYC) : CAP_FILT_CYC;
  assign cap_if.limit = filt_lim;
  assign cap_if.raw = (ded_s2_ff ~^ DED_ACT_HIGH) && !DED_IS_TRIP;

  mdiob_filt u_cap_filt (
    .clk(CLK),
    .rst_b(RST_B),
    .fi(cap_if)
  );

  // Latch the position on each filtered active edge.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CAP_VALUE <= '0;
      CAP_STB <= 1'b0;
    end else begin
      CAP_STB <= cap_if.rise;
      if (cap_if.rise) CAP_VALUE <= POS_COUNT;
    end
  end

  // ----------------------------------------------------------------
  // Trip output.
  // ----------------------------------------------------------------
  logic trip_hit;

  // Full 32-bit compare; fire is one cycle, well inside the response time.
  assign trip_hit = DED_IS_TRIP && (POS_COUNT == TRIP_VALUE);

  // Fired state is sticky until rearmed or trip mode is left; a new hit wins over the rearm.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TRIP_FIRED <= 1'b0;
      DED_OUT <= 1'b0;
      DED_OE_B <= 1'b1;
    end else begin
      if (trip_hit) TRIP_FIRED <= 1'b1;
      else if (TRIP_REARM || !DED_IS_TRIP) TRIP_FIRED <= 1'b0;
      DED_OUT <= (trip_hit || (TRIP_FIRED && !TRIP_REARM && DED_IS_TRIP)) ~^ DED_ACT_HIGH;
      DED_OE_B <= !DED_IS_TRIP;
    end
  end

  // ----------------------------------------------------------------
  // Analog input.
  // ----------------------------------------------------------------
  // Hold the latest 10-bit conversion and flag it against the threshold.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ANA_VALUE <= '0;
      ANA_ABOVE <= 1'b0;
    end else if (ADC_VALID) begin
      ANA_VALUE <= ADC_DATA;
      ANA_ABOVE <= ADC_DATA >= ANA_THRESH;
    end
  end
endmodule // mdiob_top

// File: mdiob_pins_model.sv
module mdiob_pins_model (
  // Design side.
  input wire logic [7:0] pt_out,
  input wire logic [7:0] pt_oe_b,
  input wire logic ded_out,
  input wire logic ded_oe_b,
  // Sensor side.
  input wire logic [7:0] ext_pt,
  input wire logic ext_ded_low,
  // Resolved pin levels.
  output logic [7:0] pt_in,
  output logic ded_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven point shows the drive level, a released one the sensor level.
  assign pt_in = (pt_out & ~pt_oe_b) | (ext_pt & pt_oe_b);
  // The capture line has a pull-up, so a released line reads high.
  assign ded_in = ded_oe_b ? ~ext_ded_low : ded_out;
endmodule // mdiob_pins_model

// File: mdiob_top_props.sv
module mdiob_top_props (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Points and motion state.
  input wire logic [7:0] PT_OUT,
  input wire logic [7:0] CFG_IS_OUT,
  input wire logic [7:0] CFG_ACT_HIGH,
  input wire logic [23:0] CFG_FUNC,
  input wire logic MOT_MOVING,
  input wire logic MOT_FAULT,
  input wire logic MOT_STALL,
  input wire logic ENC_PRESENT,
  input wire logic MOT_VEL_CHG,
  // Group read.
  input wire logic GRP_RD,
  input wire logic GRP_RVALID,
  // Dedicated point.
  input wire logic DED_IS_TRIP,
  input wire logic DED_ACT_HIGH,
  input wire logic DED_OUT,
  input wire logic [31:0] POS_COUNT,
  input wire logic [31:0] TRIP_VALUE,
  input wire logic TRIP_REARM,
  input wire logic TRIP_FIRED,
  input wire logic CAP_STB,
  input wire logic [31:0] CAP_VALUE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Points one..four are active-high outputs with the four motion functions.
  wire fn_ok = CFG_IS_OUT[3:0] == 4'hF && CFG_ACT_HIGH[3:0] == 4'hF && CFG_FUNC[11:0] == 12'h8D1;
  // A compare hit on the position count in trip mode.
  sequence trip_hit;
    DED_IS_TRIP && POS_COUNT == TRIP_VALUE;
  endsequence
  // The fired trip with no rearm in the same cycle.
  sequence trip_kept;
    TRIP_FIRED && DED_IS_TRIP && !TRIP_REARM;
  endsequence
  moving_out_a: assert property ($past(fn_ok) && $past(RST_B) |-> PT_OUT[0] == $past(MOT_MOVING))
    else $error("moving output wrong");
  fault_out_a: assert property ($past(fn_ok) && $past(RST_B) |-> PT_OUT[1] == $past(MOT_FAULT))
    else $error("fault output wrong");
  stall_out_a: assert property ($past(fn_ok) && $past(RST_B) |->
    PT_OUT[2] == ($past(MOT_STALL) && $past(ENC_PRESENT)))
    else $error("stall output wrong");
  velchg_out_a: assert property ($past(fn_ok) && $past(RST_B) |-> PT_OUT[3] == $past(MOT_VEL_CHG))
    else $error("velocity output wrong");
  read_answer_a: assert property (GRP_RD |=> GRP_RVALID)
    else $error("read answer missing");
  trip_fire_a: assert property (trip_hit |=> TRIP_FIRED && DED_OUT == DED_ACT_HIGH)
    else $error("trip did not fire");
  trip_hold_a: assert property (trip_kept |=> TRIP_FIRED)
    else $error("trip dropped early");
  // The strobe and the value are launched together, on the same edge that takes the position.
  cap_value_a: assert property (CAP_STB |-> CAP_VALUE == $past(POS_COUNT))
    else $error("capture value wrong");
endmodule // mdiob_top_props
bind mdiob_top mdiob_top_props u_props (.CLK(CLK), .RST_B(RST_B), .PT_OUT(PT_OUT), .CFG_IS_OUT(CFG_IS_OUT),
  .CFG_ACT_HIGH(CFG_ACT_HIGH), .CFG_FUNC(CFG_FUNC), .MOT_MOVING(MOT_MOVING), .MOT_FAULT(MOT_FAULT),
  .MOT_STALL(MOT_STALL), .ENC_PRESENT(ENC_PRESENT), .MOT_VEL_CHG(MOT_VEL_CHG), .GRP_RD(GRP_RD),
  .GRP_RVALID(GRP_RVALID), .DED_IS_TRIP(DED_IS_TRIP), .DED_ACT_HIGH(DED_ACT_HIGH), .DED_OUT(DED_OUT),
  .POS_COUNT(POS_COUNT), .TRIP_VALUE(TRIP_VALUE), .TRIP_REARM(TRIP_REARM), .TRIP_FIRED(TRIP_FIRED),
  .CAP_STB(CAP_STB), .CAP_VALUE(CAP_VALUE));

// File: mdiob_top_tb_top.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module mdiob_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] is_out = 8'h00, act_high = 8'h7F, ext_pt = 8'h96, wdata = 8'h00, pt_in, pt_out, pt_oe_b, rdata;
  logic [23:0] func = 24'h000000;
  logic [4:0] mot = 5'h00;
  logic [1:0] sel = 2'h0;
  logic wr = 1'h0, rd = 1'h0, is_trip = 1'h0, rearm = 1'h0, adc_vld = 1'h0, ext_ded_low = 1'h0;
  logic rvalid, ded_in, ded_out, ded_oe_b, cap_stb, fired, above;
  logic [9:0] adc_data = 10'h000, ana_val;
  logic [11:0] rdec;
  logic [31:0] pos = 32'h00000000, trip_val = 32'hFFFFFFFF, cap_val;
  int n_mismatch = 0, n_tests = 0, n_cap = 0;
  // Filter setting below the minimum, so the design must clamp it.
  logic [10:0] filt_cyc = 11'h000;
  // Clock, a free running position count and a capture strobe counter.
  always #4 clk = ~clk;
  always @(posedge clk) pos <= pos + 32'h00000001;
  always @(negedge clk) if (cap_stb === 1'h1) n_cap++;
  mdiob_top dut (.CLK(clk), .RST_B(rst_b), .PT_IN(pt_in), .PT_OUT(pt_out), .PT_OE_B(pt_oe_b),
    .CFG_IS_OUT(is_out), .CFG_ACT_HIGH(act_high), .CFG_FUNC(func), .MOT_MOVING(mot[0]), .MOT_FAULT(mot[1]),
    .MOT_STALL(mot[2]), .ENC_PRESENT(mot[3]), .MOT_VEL_CHG(mot[4]), .GRP_SEL(sel), .GRP_WR(wr),
    .GRP_WDATA(wdata), .GRP_RD(rd), .GRP_RDATA(rdata), .GRP_RDEC(rdec), .GRP_RVALID(rvalid), .DED_IN(ded_in),
    .DED_OUT(ded_out), .DED_OE_B(ded_oe_b), .DED_IS_TRIP(is_trip), .DED_ACT_HIGH(1'h0), .CAP_FILT_CYC(filt_cyc),
    .POS_COUNT(pos), .CAP_VALUE(cap_val), .CAP_STB(cap_stb), .TRIP_VALUE(trip_val), .TRIP_REARM(rearm),
    .TRIP_FIRED(fired), .ADC_VALID(adc_vld), .ADC_DATA(adc_data), .ANA_THRESH(10'h100), .ANA_VALUE(ana_val),
    .ANA_ABOVE(above));
  mdiob_pins_model pins (.pt_out(pt_out), .pt_oe_b(pt_oe_b), .ded_out(ded_out), .ded_oe_b(ded_oe_b),
    .ext_pt(ext_pt), .ext_ded_low(ext_ded_low), .pt_in(pt_in), .ded_in(ded_in));
  // Waits a number of rising edges.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Writes a group with a one-cycle strobe.
  task automatic grp_wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    sel <= s;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // Reads a group and compares the answer in its valid cycle.
  task automatic grp_rd(input logic [1:0] s, input logic [7:0] e, input string nm);
    @(posedge clk);
    sel <= s;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    `CHK("rvalid", 1'h1, rvalid)
    `CHK(nm, e, rdata)
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  // Main test sequence.
  initial begin
    step(5);
    rst_b <= 1'h1;
    step(4);
    `CHK("released", 8'hFF, pt_oe_b)
    grp_rd(2'h0, 8'h06, "lower");
    grp_rd(2'h1, 8'h01, "upper");
    grp_rd(2'h2, 8'h16, "all");
    `CHK("decimal", 12'h022, rdec)
    $display("group read test done");
    step(1);
    is_out <= 8'hFF;
    grp_wr(2'h0, 8'h0A);
    grp_wr(2'h1, 8'h05);
    step(5);
    `CHK("driven", 8'h00, pt_oe_b)
    grp_rd(2'h2, 8'h5A, "halves");
    grp_wr(2'h2, 8'hC3);
    grp_wr(2'h3, 8'hFF);
    step(5);
    grp_rd(2'h2, 8'hC3, "whole");
    `CHK("decimal three", 12'h195, rdec)
    `CHK("pin low", 1'h0, pt_out[7])
    grp_rd(2'h3, 8'h00, "no group");
    $display("group write test done");
    step(1);
    func <= 24'h0008D1;
    act_high <= 8'hFF;
    for (int i = 0; i < 32; i++) begin
      step(1);
      mot <= i[4:0];
      step(5);
      grp_rd(2'h0, {4'h0, i[4], i[2] & i[3], i[1], i[0]}, "functions");
    end
    $display("function test done");
    step(1);
    ext_ded_low <= 1'h1;
    step(3);
    ext_ded_low <= 1'h0;
    step(20);
    `CHK("short pulse", 0, n_cap)
    ext_ded_low <= 1'h1;
    step(20);
    ext_ded_low <= 1'h0;
    step(20);
    `CHK("captures", 1, n_cap)
    $display("capture test done");
    trip_val <= pos + 32'h0000000A;
    is_trip <= 1'h1;
    step(5);
    #1;
    `CHK("early trip", 1'h0, fired)
    step(10);
    #1;
    `CHK("fired", 1'h1, fired)
    `CHK("trip pin", 1'h0, ded_out)
    `CHK("trip drive", 1'h0, ded_oe_b)
    step(1);
    rearm <= 1'h1;
    step(1);
    rearm <= 1'h0;
    step(1);
    #1;
    `CHK("rearmed", 1'h0, fired)
    `CHK("trip idle", 1'h1, ded_out)
    $display("trip test done");
    step(1);
    adc_data <= 10'h2A5;
    adc_vld <= 1'h1;
    step(1);
    adc_vld <= 1'h0;
    #1;
    `CHK("analog", 10'h2A5, ana_val)
    `CHK("above", 1'h1, above)
    step(1);
    adc_data <= 10'h0FF;
    adc_vld <= 1'h1;
    step(1);
    adc_vld <= 1'h0;
    step(2);
    #1;
    `CHK("analog low", 10'h0FF, ana_val)
    `CHK("below", 1'h0, above)
    $display("analog test done");
    test_done();
  end
endmodule // mdiob_top_tb_top
